// [bstap_ctrl.sv]
`timescale 1ns/100ps
// How it works
// - State steps only on sampled rising test clock edges using mode select.
// - Reset enters Test-Logic-Reset, IDCODE current; system runs normally.
// - Select-DR-Scan holds registers; low goes Capture-DR, high Select-IR-Scan.
// - Capture-DR loads the selected register if allowed; then Shift or Exit1.
// - Shift-DR shifts selected register toward output; others hold.
// - Exit1-DR goes Update-DR on high, Pause-DR on low.
// - Pause-DR waits on low; Exit2-DR goes Update on high, Shift on low.
// - Update-DR falling edge copies shift path into output latches.
// - Update states go Idle on low, Select-DR on high; Idle holds.
// - Select-IR-Scan holds; low goes Capture-IR, high Test-Logic-Reset.
// - Capture-IR loads fixed constant; high Exit1-IR, low Shift-IR.
// - Exit1-IR goes Pause-IR on low, Update-IR on high.
// - Pause-IR waits on low; Exit2-IR goes Update on high, Shift on low.
// - Update-IR entry falling edge latches the new current instruction.
// - Codes 000,001,010 pick boundary or ID; 011,100,111 pick bypass.
// - Sample/preload captures pin levels and shifts without affecting pins.
// - Extest drives outputs from boundary latches and samples inputs.
// - Bypass routes serial data through one bypass stage.
// - Idcode loads identity code in Capture-DR then shifts it out.
// - Highz floats every pin output; bypass in serial path.
// - Clamp drives outputs from boundary latches, bypass in serial path.
// - Identification register is 32 bits, selected by IDCODE and reset state.
module bstap_ctrl
	import bstap_pkg::*;
#(
	parameter int          BSR_W   = BSTAP_BSR_W,
	parameter logic [31:0] ID_CODE = BSTAP_ID_DEFAULT
)
(
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst,
	input  wire logic             i_test_clock_in,
	input  wire logic             i_test_mode_select_in,
	input  wire logic             i_test_serial_in,
	input  wire logic [BSR_W-1:0] i_pin_in,
	input  wire logic [BSR_W-1:0] i_sys_out,
	input  wire logic [BSR_W-1:0] i_sys_oe_n,
	output logic                  o_test_serial_out,
	output logic                  o_test_serial_oe_n,
	output logic [BSR_W-1:0]      o_pin_out,
	output logic [BSR_W-1:0]      o_pin_oe_n,
	output logic [2:0]            o_instr
);

	// The shift slices below need at least two boundary cells.
	if (BSR_W < 2)
	begin : g_bad_bsr_w
		$error("BSR_W must be at least two");
	end

	if (BSTAP_IR_W != 3 || BSTAP_ID_W != 32)
	begin : g_bad_pkg_w
		$error("Instruction or identity width differs from the ports");
	end

	if (BSTAP_IR_CAPTURE[1:0] != 2'h1)
	begin : g_bad_capture
		$error("Instruction capture value must end in binary 01");
	end

	bstap_pins_t           meta_r;
	bstap_pins_t           sync_r;
	logic [BSR_W-1:0]      pin_meta_r;
	logic [BSR_W-1:0]      pin_sync_r;
	logic                  clk_prev_r;
	logic                  rise;
	logic                  fall;
	bstap_state_t          state_r;
	bstap_state_t          state_nxt;
	logic [BSTAP_IR_W-1:0] ir_sh_r;
	logic [BSTAP_IR_W-1:0] ir_r;
	logic [BSTAP_ID_W-1:0] id_sh_r;
	logic [BSR_W-1:0]      bsr_sh_r;
	logic [BSR_W-1:0]      bsr_lat_r;
	logic                  byp_r;
	logic                  sel_bsr;
	logic                  sel_id;
	logic                  sel_byp;
	logic                  tdo_nxt;

	// Pins are asynchronous to the system clock, so two flops first.
	always_ff @(posedge i_clk_sys)
	begin
		meta_r <= '{clk: i_test_clock_in, tms: i_test_mode_select_in,
			tdi: i_test_serial_in};
		sync_r <= meta_r;
	end

	// Pin levels are asynchronous too; a capture must never see a metastable bit.
	always_ff @(posedge i_clk_sys)
	begin
		pin_meta_r <= i_pin_in;
		pin_sync_r <= pin_meta_r;
	end

	// Reset to the idle low level so that no false edge follows reset.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			clk_prev_r <= 1'b0;
		else
			clk_prev_r <= sync_r.clk;
	end

	assign rise = sync_r.clk & ~clk_prev_r;
	assign fall = ~sync_r.clk & clk_prev_r;

	// Mode select and serial input share the clock's synchroniser delay.
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_TLR:  state_nxt = sync_r.tms ? ST_TLR  : ST_RTI;
			ST_RTI:  state_nxt = sync_r.tms ? ST_SDR  : ST_RTI;
			ST_SDR:  state_nxt = sync_r.tms ? ST_SIR  : ST_CDR;
			ST_CDR:  state_nxt = sync_r.tms ? ST_E1DR : ST_SHDR;
			ST_SHDR: state_nxt = sync_r.tms ? ST_E1DR : ST_SHDR;
			ST_E1DR: state_nxt = sync_r.tms ? ST_UDR  : ST_PDR;
			ST_PDR:  state_nxt = sync_r.tms ? ST_E2DR : ST_PDR;
			ST_E2DR: state_nxt = sync_r.tms ? ST_UDR  : ST_SHDR;
			ST_UDR:  state_nxt = sync_r.tms ? ST_SDR  : ST_RTI;
			ST_SIR:  state_nxt = sync_r.tms ? ST_TLR  : ST_CIR;
			ST_CIR:  state_nxt = sync_r.tms ? ST_E1IR : ST_SHIR;
			ST_SHIR: state_nxt = sync_r.tms ? ST_E1IR : ST_SHIR;
			ST_E1IR: state_nxt = sync_r.tms ? ST_UIR  : ST_PIR;
			ST_PIR:  state_nxt = sync_r.tms ? ST_E2IR : ST_PIR;
			ST_E2IR: state_nxt = sync_r.tms ? ST_UIR  : ST_SHIR;
			ST_UIR:  state_nxt = sync_r.tms ? ST_SDR  : ST_RTI;
			default: state_nxt = ST_TLR;
		endcase
	end

	// Only a detected rising edge moves the state, so mode select counts once.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			state_r <= ST_TLR;
		else if (rise)
			state_r <= state_nxt;
	end

	// Instruction shift stage.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			ir_sh_r <= BSTAP_IR_CAPTURE;
		else if (rise && state_r == ST_CIR)
			ir_sh_r <= BSTAP_IR_CAPTURE;
		else if (rise && state_r == ST_SHIR)
			ir_sh_r <= {sync_r.tdi, ir_sh_r[BSTAP_IR_W-1:1]};
	end

	// Current instruction; forced to IDCODE while in reset state.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			ir_r <= BSTAP_IR_IDCODE;
		else if (state_r == ST_TLR)
			ir_r <= BSTAP_IR_IDCODE;
		else if (fall && state_r == ST_UIR)
			ir_r <= ir_sh_r;
	end

	// Unlisted codes fall to the bypass stage so the serial path never opens.
	always_comb
	begin
		sel_bsr = 1'b0;
		sel_id  = 1'b0;
		sel_byp = 1'b0;
		case (ir_r)
			BSTAP_IR_EXTEST,
			BSTAP_IR_SAMPLE: sel_bsr = 1'b1;
			BSTAP_IR_IDCODE: sel_id  = 1'b1;
			default:         sel_byp = 1'b1;
		endcase
	end

	// Identification register shift stage.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			id_sh_r <= '0;
		else if (rise && sel_id && state_r == ST_CDR)
			id_sh_r <= ID_CODE;
		else if (rise && sel_id && state_r == ST_SHDR)
			id_sh_r <= {sync_r.tdi, id_sh_r[BSTAP_ID_W-1:1]};
	end

	// Boundary shift stage captures pin levels when selected.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			bsr_sh_r <= '0;
		else if (rise && sel_bsr && state_r == ST_CDR)
			bsr_sh_r <= pin_sync_r;
		else if (rise && sel_bsr && state_r == ST_SHDR)
			bsr_sh_r <= {sync_r.tdi, bsr_sh_r[BSR_W-1:1]};
	end

	// Latches move only on the Update-DR falling edge, never while shifting.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			bsr_lat_r <= '0;
		else if (fall && sel_bsr && state_r == ST_UDR)
			bsr_lat_r <= bsr_sh_r;
	end

	// Bypass stage captures zero, then shifts one bit.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			byp_r <= 1'b0;
		else if (rise && sel_byp && state_r == ST_CDR)
			byp_r <= 1'b0;
		else if (rise && sel_byp && state_r == ST_SHDR)
			byp_r <= sync_r.tdi;
	end

	// Shift-IR owns the serial path whatever instruction is current.
	always_comb
	begin
		if (state_r == ST_SHIR)
			tdo_nxt = ir_sh_r[0];
		else if (sel_id)
			tdo_nxt = id_sh_r[0];
		else if (sel_bsr)
			tdo_nxt = bsr_sh_r[0];
		else
			tdo_nxt = byp_r;
	end

	// Serial output updates on falling edges so the tester samples it stably.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			o_test_serial_out <= 1'b0;
		else if (fall)
			o_test_serial_out <= tdo_nxt;
	end

	// The line is released at the first falling edge outside a shift state.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			o_test_serial_oe_n <= 1'b1;
		else if (fall)
			o_test_serial_oe_n <= !(state_r == ST_SHDR ||
				state_r == ST_SHIR);
	end

	// Pin mux: normal path unless EXTEST, CLAMP or HIGHZ is current.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			o_pin_out  <= '0;
			o_pin_oe_n <= '1;
		end
		else
		begin
			case (ir_r)
				BSTAP_IR_EXTEST,
				BSTAP_IR_CLAMP:
				begin
					o_pin_out  <= bsr_lat_r;
					o_pin_oe_n <= '0;
				end
				BSTAP_IR_HIGHZ:
				begin
					o_pin_out  <= i_sys_out;
					o_pin_oe_n <= '1;
				end
				default:
				begin
					o_pin_out  <= i_sys_out;
					o_pin_oe_n <= i_sys_oe_n;
				end
			endcase
		end
	end

	// Mirrored on a port so that a tester can see the current instruction.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			o_instr <= BSTAP_IR_IDCODE;
		else
			o_instr <= ir_r;
	end

endmodule // bstap_ctrl

// [bstap_ctrl_props.sv]
`timescale 1ns/100ps
module bstap_ctrl_props
	import bstap_pkg::*;
#(parameter int BSR_W = 8)
(
	input wire logic             i_clk_sys,
	input wire logic             i_rst,
	input wire logic             i_test_clock_in,
	input wire logic [BSR_W-1:0] i_sys_out,
	input wire logic [BSR_W-1:0] i_sys_oe_n,
	input wire logic             o_test_serial_out,
	input wire logic             o_test_serial_oe_n,
	input wire logic [BSR_W-1:0] o_pin_out,
	input wire logic [BSR_W-1:0] o_pin_oe_n,
	input wire logic [2:0]       o_instr
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);
	// Test clock edges reach the logic late, so look two cycles back.
	sequence s_low;
		!$past(i_test_clock_in) && !$past(i_test_clock_in, 2);
	endsequence
	sequence s_held;
		!$past(i_rst) && $past(o_instr) == o_instr
			&& $past(o_instr, 2) == o_instr;
	endsequence
	AST_RST: assert property ($fell(i_rst) |-> o_instr == 3'h1
		&& o_test_serial_oe_n && &o_pin_oe_n) else $error("bad reset");
	AST_IR_FALL: assert property (
		$changed(o_instr) && o_instr != 3'h1 |-> s_low)
		else $error("instr moved");
	AST_OE_FALL: assert property ($changed(o_test_serial_oe_n)
		|-> s_low) else $error("oe moved");
	AST_TDO_HOLD: assert property ($rose(i_test_clock_in)
		|-> ##4 $stable(o_test_serial_out) [*8]) else $error("tdo moved");
	AST_HIGHZ: assert property (o_instr == 3'h4 ##0 s_held
		|-> &o_pin_oe_n) else $error("pins driven");
	AST_EXTEST: assert property (o_instr == 3'h0 ##0 s_held
		|-> o_pin_oe_n == '0) else $error("pins float");
	AST_CLAMP: assert property (o_instr == 3'h3 ##0 s_held
		|-> $stable(o_pin_out) && o_pin_oe_n == '0) else $error("clamp");
	AST_SYS: assert property (
		o_instr inside {3'h1, 3'h2, 3'h7} ##0 s_held
		|-> o_pin_out == $past(i_sys_out) && o_pin_oe_n == $past(i_sys_oe_n))
		else $error("sys path");
endmodule // bstap_ctrl_props
bind bstap_ctrl bstap_ctrl_props #(.BSR_W(BSR_W)) props_u (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_test_clock_in(i_test_clock_in),
	.i_sys_out(i_sys_out), .i_sys_oe_n(i_sys_oe_n),
	.o_test_serial_out(o_test_serial_out),
	.o_test_serial_oe_n(o_test_serial_oe_n),
	.o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n), .o_instr(o_instr)
);

// [bstap_pkg.sv]
package bstap_pkg;

	// Instruction codes.
	localparam logic [2:0] BSTAP_IR_EXTEST  = 3'h0;
	localparam logic [2:0] BSTAP_IR_IDCODE  = 3'h1;
	localparam logic [2:0] BSTAP_IR_SAMPLE  = 3'h2;
	localparam logic [2:0] BSTAP_IR_CLAMP   = 3'h3;
	localparam logic [2:0] BSTAP_IR_HIGHZ   = 3'h4;
	localparam logic [2:0] BSTAP_IR_BYPASS  = 3'h7;
	// Capture value: 01 nearest the serial output, top bit fixed at zero.
	localparam logic [2:0] BSTAP_IR_CAPTURE = 3'h1;
	localparam int         BSTAP_IR_W       = 3;
	localparam int         BSTAP_ID_W       = 32;
	// Identity code; the value is arbitrary.
	localparam logic [31:0] BSTAP_ID_DEFAULT = 32'h1234_5679;
	localparam int         BSTAP_BSR_W      = 8;

	typedef enum logic [15:0] {
		ST_TLR  = 16'h0001,
		ST_RTI  = 16'h0002,
		ST_SDR  = 16'h0004,
		ST_CDR  = 16'h0008,
		ST_SHDR = 16'h0010,
		ST_E1DR = 16'h0020,
		ST_PDR  = 16'h0040,
		ST_E2DR = 16'h0080,
		ST_UDR  = 16'h0100,
		ST_SIR  = 16'h0200,
		ST_CIR  = 16'h0400,
		ST_SHIR = 16'h0800,
		ST_E1IR = 16'h1000,
		ST_PIR  = 16'h2000,
		ST_E2IR = 16'h4000,
		ST_UIR  = 16'h8000
	} bstap_state_t;

	// Test pins grouped as they travel together.
	typedef struct packed {
		logic clk;
		logic tms;
		logic tdi;
	} bstap_pins_t;

endpackage

// [bstap_tester.sv]
`timescale 1ns/100ps
module bstap_tester
	import bstap_pkg::*;
(
	output bstap_pins_t o_pins,
	input  wire logic   i_tdo,
	input  wire logic   i_tdo_oe_n
);
	logic oe_seen;
	initial o_pins = '0;
	// Half a period of setup and hold; the clock idles low between calls.
	task automatic tick(input logic tms, input logic tdi, output logic tdo);
		o_pins.tms = tms;
		o_pins.tdi = tdi;
		#80;
		tdo = i_tdo;
		oe_seen = i_tdo_oe_n;
		o_pins.clk = 1'b1;
		#80;
		o_pins.clk = 1'b0;
	endtask
endmodule // bstap_tester

// [tb_boundary_scan_tap_controller.sv]
`timescale 1ns/100ps
module tb_boundary_scan_tap_controller;
	import bstap_pkg::*;
	// The identity value is arbitrary.
	localparam logic [31:0] ID = 32'h5a3c_0f96;
	logic        clk = 1'b0, rst = 1'b1, tdo, toe;
	// A released serial line floats up to its pull-up level.
	wire         tdo_line = toe ? 1'b1 : tdo;
	logic [2:0]  instr;
	logic [7:0]  pin_in = 8'h00, sys_out = 8'h00, sys_oe_n = 8'hff;
	logic [7:0]  pout, poe, latch;
	logic [31:0] lf = 32'h836f409d, dout, d, e;
	bstap_pins_t pins;
	int          fails = 0, tests_run = 0, mi;
	int          codes[6] = '{2, 0, 3, 4, 1, 7};
	bit          pat[5] = '{1, 0, 0, 1, 0};
	function automatic logic [31:0] nx(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		#1;
		lf = nx(lf);
		{sys_oe_n, sys_out} = lf[15:0];
	end
	bstap_ctrl #(.ID_CODE(ID)) dut_u (
		.i_clk_sys(clk), .i_rst(rst), .i_test_clock_in(pins.clk),
		.i_test_mode_select_in(pins.tms), .i_test_serial_in(pins.tdi),
		.i_pin_in(pin_in), .i_sys_out(sys_out), .i_sys_oe_n(sys_oe_n),
		.o_test_serial_out(tdo), .o_test_serial_oe_n(toe),
		.o_pin_out(pout), .o_pin_oe_n(poe), .o_instr(instr)
	);
	bstap_tester pt_u (.o_pins(pins), .i_tdo(tdo_line), .i_tdo_oe_n(toe));
	task automatic chk(string n, logic [31:0] s, logic [31:0] x);
		tests_run++;
		if (s !== x)
		begin
			$display("mismatch %s exp %h seen %h", n, x, s);
			fails++;
		end
	endtask
	task automatic scan(int n, bit ir, bit pz, logic [31:0] v);
		logic t;
		pt_u.tick(1, 0, t);
		if (ir)
			pt_u.tick(1, 0, t);
		pt_u.tick(0, 0, t);
		if (pz)
			foreach (pat[i])
				pt_u.tick(pat[i], 0, t);
		else
			pt_u.tick(0, 0, t);
		for (int i = 0; i < n; i++)
		begin
			pt_u.tick(i == n - 1, v[i], t);
			chk("oe_n", 32'(pt_u.oe_seen), 0);
			dout = {t, dout[31:1]};
		end
		dout = dout >> (32 - n);
		pt_u.tick(1, 0, t);
		chk("oe_n", 32'(pt_u.oe_seen), 1);
		pt_u.tick(0, 0, t);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (50000) @(posedge clk);
		fails++;
		test_done;
	end
	initial
	begin
		logic t;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk("instr", 32'(instr), 1);
		pt_u.tick(0, 0, t);
		scan(32, 0, 0, lf);
		chk("id", dout, ID);
		foreach (codes[k])
		begin
			mi = codes[k];
			scan(3, 1, k[0], 32'(mi));
			chk("ir", dout, 1);
			chk("instr", 32'(instr), mi);
			d = lf;
			pin_in = d[31:24];
			scan(mi == 1 ? 32 : 8, 0, !k[0], d);
			e = {24'h0, d[6:0], 1'b0};
			if (mi inside {0, 2})
				e = 32'(pin_in);
			if (mi == 1)
				e = ID;
			chk("dr", dout, e);
			if (mi inside {0, 2})
				latch = d[7:0];
			if (mi inside {0, 3})
				chk("pins", {poe, pout}, {8'h00, latch});
			if (mi == 4)
				chk("oe", 32'(poe), 32'hff);
		end
		pt_u.tick(1, 0, t);
		pt_u.tick(0, 0, t);
		pt_u.tick(0, 0, t);
		repeat (5)
			pt_u.tick(1, 0, t);
		chk("instr", 32'(instr), 1);
		test_done;
	end
endmodule // tb_boundary_scan_tap_controller
